// ==== irrc_pkg.sv ====
// constants, field layouts and states for the interrupt remap request checker
package irrc_pkg;
    // fault reason codes
    localparam logic [7:0] FR_RSVD_REQ = 8'h20;
    localparam logic [7:0] FR_BOUNDS = 8'h21;
    localparam logic [7:0] FR_NOT_PRESENT = 8'h22;
    localparam logic [7:0] FR_TABLE_ERR = 8'h23;
    localparam logic [7:0] FR_BAD_ENTRY = 8'h24;
    localparam logic [7:0] FR_COMPAT_BLOCKED = 8'h25;
    localparam logic [7:0] FR_SID_MISMATCH = 8'h26;
    localparam logic [7:0] FR_DESC_ERR = 8'h27;
    localparam logic [7:0] FR_DESC_RSVD = 8'h28;

    // request decode
    localparam logic [11:0] INT_WINDOW = 12'hfee;
    localparam logic [3:0] DWORD_BE = 4'hf;
    localparam int ADDR_FMT_BIT = 4;
    localparam int ADDR_SHV_BIT = 3;
    localparam int ADDR_H15_BIT = 2;
    localparam int ADDR_HLO_LSB = 5;
    localparam int ADDR_HLO_MSB = 19;
    localparam int ENTRY_SHIFT = 4;

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TSIZE = 8'h04;
    localparam logic [7:0] REG_BASE = 8'h08;
    localparam logic [7:0] REG_HAW = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_FCNT = 8'h14;
    localparam logic [7:0] REG_FWDCNT = 8'h18;

    // control and status register fields
    localparam int CTRL_REMAP_EN_BIT = 0;
    localparam int CTRL_COMPAT_OK_BIT = 1;
    localparam int CTRL_EXTENDED_INT_MODE_ENABLE_BIT = 2;
    localparam int CTRL_COHERENT_BIT = 3;
    localparam int CTRL_FLUSH_BIT = 4;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_REASON_LSB = 8;

    // reset values
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [16:0] TSIZE_RESET = 17'h0_0000;
    localparam logic [31:0] BASE_RESET = 32'h0000_0000;
    localparam logic [5:0] HAW_RESET = 6'h20;

    // table entry layout
    localparam int E_P_BIT = 0;
    localparam int E_FPD_BIT = 1;
    localparam int E_DM_BIT = 2;
    localparam int E_RH_BIT = 3;
    localparam int E_TM_BIT = 4;
    localparam int E_DLM_LSB = 5;
    localparam int E_IM_BIT = 15;
    localparam int E_VEC_LSB = 16;
    localparam int E_DEST_LSB = 32;
    localparam int E_SID_LSB = 64;
    localparam int E_SQ_LSB = 80;
    localparam int E_SVT_LSB = 82;
    localparam logic [127:0] E_RSVD_MASK = 128'hffff_ffff_fff0_0000_0000_0000_ff00_7f00;

    // requester verify encodings
    localparam logic [1:0] SVT_NONE = 2'h0;
    localparam logic [1:0] SVT_SID = 2'h1;
    localparam logic [1:0] SVT_BUS = 2'h2;

    typedef enum logic [2:0] {ST_IDLE, ST_DECODE, ST_FETCH, ST_VERIFY, ST_SEND, ST_POST} irrc_state_e;
endpackage

// ==== irrc_entry_cache.sv ====
// direct-mapped cache of remap table entries
module irrc_entry_cache import irrc_pkg::*; #(
    parameter int SETS_LOG = 3,
    parameter int IDX_W = 17,
    parameter int ENTRY_W = 128
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic [IDX_W-1:0] look_idx,
    output logic look_hit,
    output logic [ENTRY_W-1:0] look_entry,
    input wire logic fill_valid,
    input wire logic [IDX_W-1:0] fill_idx,
    input wire logic [ENTRY_W-1:0] fill_entry
);
    localparam int SETS = 1 << SETS_LOG;
    localparam int TAG_W = IDX_W - SETS_LOG;

    typedef struct packed {
        logic [SETS-1:0] valid;
        logic [SETS-1:0][TAG_W-1:0] tag;
        logic [SETS-1:0][ENTRY_W-1:0] data;
    } irrc_cache_s;

    irrc_cache_s state_reg;
    irrc_cache_s state_next;
    logic [SETS_LOG-1:0] look_set;
    logic [SETS_LOG-1:0] fill_set;

    assign look_set = look_idx[SETS_LOG-1:0];
    assign fill_set = fill_idx[SETS_LOG-1:0];
    assign look_hit = state_reg.valid[look_set] && (state_reg.tag[look_set] == look_idx[IDX_W-1:SETS_LOG]);
    assign look_entry = state_reg.data[look_set];

    always_comb begin
        state_next = state_reg;
        if (fill_valid) begin
            state_next.valid[fill_set] = 1'b1;
            state_next.tag[fill_set] = fill_idx[IDX_W-1:SETS_LOG];
            state_next.data[fill_set] = fill_entry;
        end
        // flush wins so a stale entry never survives an invalidate
        if (flush) begin
            state_next.valid = '0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule

// ==== irrc_checker.sv ====
// interrupt remap request checker: decode, bounds, entry lookup, verify, forward or fault
// Functional notes
// - interrupt means dword write into window
// - remap disabled: everything handled as compatibility
// - format bit selects compatibility or remappable
// - block compatibility under extended mode or with compat_ok clear, fault 25h
// - otherwise compatibility request passes unchanged
// - reserved request bits nonzero: fault 20h
// - index is handle, or handle plus subhandle
// - index or entry address out of range: 21h
// - entry from cache on hit, else memory
// - non-coherent: entry fetches are non-snooped
// - entry not present: qualified fault 22h
// - requester verify failure: qualified fault 26h
// - misprogrammed entry: qualified fault 24h (reserved bits checked on non-posted entries only)
// - posted-mode entry handed to posting logic
// - remapped output carries trigger level asserted
// - qualified faults reported only without suppress
// - table access error: unqualified fault 23h
// - posted descriptor faults 27h and 28h
// - every block goes through fault path
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
module irrc_checker import irrc_pkg::*; #(
    parameter int CACHE_SETS_LOG = 3
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [3:0] req_byteenable,
    input wire logic [31:0] req_addr,
    input wire logic [31:0] req_data,
    input wire logic [15:0] req_source_id,
    output logic mem_req,
    output logic [32:0] mem_addr,
    output logic mem_nosnoop,
    input wire logic mem_ack,
    input wire logic mem_err,
    input wire logic [127:0] mem_rdata,
    output logic out_valid,
    input wire logic out_ready,
    output logic [31:0] out_addr,
    output logic [31:0] out_data,
    output logic [31:0] out_dest,
    output logic out_remapped,
    output logic post_valid,
    input wire logic post_ready,
    input wire logic post_desc_err,
    input wire logic post_desc_rsvd,
    output logic [16:0] post_index,
    output logic [127:0] post_entry,
    output logic fault_valid,
    output logic [7:0] fault_reason,
    output logic fault_qualified,
    output logic fault_report,
    output logic [15:0] fault_source_id,
    output logic [16:0] fault_index
);
    typedef struct packed {
        irrc_state_e st;
        logic [31:0] addr;
        logic [31:0] data;
        logic [15:0] requester_source_tag;
        logic [16:0] idx;
        logic [127:0] entry;
        logic mem_req;
        logic [32:0] mem_addr;
        logic out_valid;
        logic [31:0] out_addr;
        logic [31:0] out_data;
        logic [31:0] out_dest;
        logic out_remapped;
        logic post_valid;
        logic fault_valid;
        logic [7:0] fault_reason;
        logic fault_qualified;
        logic fault_report;
        logic [3:0] ctrl;
        logic [16:0] tsize;
        logic [31:0] base;
        logic [5:0] host_addr_width;
        logic [7:0] last_reason;
        logic [15:0] fault_cnt;
        logic [15:0] fwd_cnt;
        logic flush;
        logic bus_ack;
        logic [31:0] rdata;
    } irrc_main_s;

    irrc_main_s state_reg;
    irrc_main_s state_next;

    logic in_is_int;
    logic [15:0] in_handle;
    logic [16:0] in_idx;
    logic remap_en;
    logic compat_ok;
    logic extended_int_mode_enable;
    logic coherent;
    logic dec_remappable;
    logic dec_compat_block;
    logic dec_rsvd_bad;
    logic [32:0] ent_addr;
    logic dec_bounds_bad;
    logic cache_hit;
    logic [127:0] cache_entry;
    logic fill_valid;
    logic e_p;
    logic e_fpd;
    logic e_im;
    logic [1:0] e_svt;
    logic [1:0] e_sq;
    logic [15:0] e_sid;
    logic [15:0] sid_mask;
    logic e_svt_bad;
    logic e_rsvd_bad;
    logic sid_ok;
    logic bus_req;

    function automatic irrc_main_s raise_fault(input irrc_main_s s, input logic [7:0] reason,
                                               input logic qual, input logic fault_report_suppress);
        irrc_main_s r;
        r = s;
        r.fault_valid = 1'b1;
        r.fault_reason = reason;
        r.fault_qualified = qual;
        r.fault_report = !qual || !fault_report_suppress;
        r.last_reason = reason;
        r.fault_cnt = s.fault_cnt + 16'h0001;
        r.st = ST_IDLE;
        return r;
    endfunction

    assign remap_en = state_reg.ctrl[CTRL_REMAP_EN_BIT];
    assign compat_ok = state_reg.ctrl[CTRL_COMPAT_OK_BIT];
    assign extended_int_mode_enable = state_reg.ctrl[CTRL_EXTENDED_INT_MODE_ENABLE_BIT];
    assign coherent = state_reg.ctrl[CTRL_COHERENT_BIT];

    assign in_is_int = req_write && (req_byteenable == DWORD_BE) && (req_addr[31:20] == INT_WINDOW);
    assign in_handle = {req_addr[ADDR_H15_BIT], req_addr[ADDR_HLO_MSB:ADDR_HLO_LSB]};
    assign in_idx = req_addr[ADDR_SHV_BIT] ? ({1'b0, in_handle} + {1'b0, req_data[15:0]}) : {1'b0, in_handle};

    assign dec_remappable = remap_en && state_reg.addr[ADDR_FMT_BIT];
    assign dec_compat_block = remap_en && !state_reg.addr[ADDR_FMT_BIT] && (extended_int_mode_enable || !compat_ok);
    assign dec_rsvd_bad = state_reg.addr[ADDR_SHV_BIT] && (state_reg.data[31:16] != 16'h0000);
    assign ent_addr = {1'b0, state_reg.base[31:ENTRY_SHIFT], 4'h0} + {12'h000, state_reg.idx, 4'h0};
    assign dec_bounds_bad = (state_reg.idx >= state_reg.tsize) || ((ent_addr >> state_reg.host_addr_width) != 33'h0_0000_0000);

    assign e_p = state_reg.entry[E_P_BIT];
    assign e_fpd = state_reg.entry[E_FPD_BIT];
    assign e_im = state_reg.entry[E_IM_BIT];
    assign e_svt = state_reg.entry[E_SVT_LSB +: 2];
    assign e_sq = state_reg.entry[E_SQ_LSB +: 2];
    assign e_sid = state_reg.entry[E_SID_LSB +: 16];
    assign e_svt_bad = (e_svt == 2'h3);
    assign e_rsvd_bad = (state_reg.entry & E_RSVD_MASK) != '0;
    // qualifier drops the low function bits from the compare
    assign sid_mask = (e_sq == 2'h0) ? 16'hffff : (e_sq == 2'h1) ? 16'hfffb : (e_sq == 2'h2) ? 16'hfff9 : 16'hfff8;
    always_comb begin
        case (e_svt)
            SVT_NONE: sid_ok = 1'b1;
            SVT_SID: sid_ok = (state_reg.requester_source_tag & sid_mask) == (e_sid & sid_mask);
            SVT_BUS: sid_ok = (state_reg.requester_source_tag[15:8] >= e_sid[15:8]) && (state_reg.requester_source_tag[15:8] <= e_sid[7:0]);
            default: sid_ok = 1'b0;
        endcase
    end

    assign fill_valid = (state_reg.st == ST_FETCH) && mem_ack && !mem_err;

    irrc_entry_cache #(
        .SETS_LOG(CACHE_SETS_LOG),
        .IDX_W(17),
        .ENTRY_W(128)
    ) u_cache (
        .sys_clk(sys_clk),
        .rst(rst),
        .flush(state_reg.flush),
        .look_idx(state_reg.idx),
        .look_hit(cache_hit),
        .look_entry(cache_entry),
        .fill_valid(fill_valid),
        .fill_idx(state_reg.idx),
        .fill_entry(mem_rdata)
    );

    assign bus_req = avs_read || avs_write;
    // one wait cycle, then the answer from the flops
    assign avs_waitrequest = bus_req && !state_reg.bus_ack;

    always_comb begin
        state_next = state_reg;
        state_next.fault_valid = 1'b0;
        state_next.flush = 1'b0;
        state_next.bus_ack = bus_req && !state_reg.bus_ack;
        if (avs_read && !state_reg.bus_ack) begin
            state_next.rdata = 32'h0000_0000;
            case (avs_address)
                REG_CTRL: state_next.rdata[3:0] = state_reg.ctrl;
                REG_TSIZE: state_next.rdata[16:0] = state_reg.tsize;
                REG_BASE: state_next.rdata = state_reg.base;
                REG_HAW: state_next.rdata[5:0] = state_reg.host_addr_width;
                REG_STATUS: begin
                    state_next.rdata[STATUS_BUSY_BIT] = state_reg.st != ST_IDLE;
                    state_next.rdata[STATUS_REASON_LSB +: 8] = state_reg.last_reason;
                end
                REG_FCNT: state_next.rdata[15:0] = state_reg.fault_cnt;
                REG_FWDCNT: state_next.rdata[15:0] = state_reg.fwd_cnt;
                default: state_next.rdata = 32'h0000_0000;
            endcase
        end
        if (avs_write && state_reg.bus_ack) begin
            case (avs_address)
                REG_CTRL: begin
                    state_next.ctrl = avs_writedata[3:0];
                    state_next.flush = avs_writedata[CTRL_FLUSH_BIT];
                end
                REG_TSIZE: state_next.tsize = avs_writedata[16:0];
                REG_BASE: state_next.base = avs_writedata;
                REG_HAW: state_next.host_addr_width = avs_writedata[5:0];
                default: state_next.flush = 1'b0;
            endcase
        end

        case (state_reg.st)
            ST_IDLE: begin
                // non-interrupt writes are taken and dropped
                if (req_valid && in_is_int) begin
                    state_next.st = ST_DECODE;
                    state_next.addr = req_addr;
                    state_next.data = req_data;
                    state_next.requester_source_tag = req_source_id;
                    state_next.idx = in_idx;
                end
            end
            ST_DECODE: begin
                if (!dec_remappable) begin
                    if (dec_compat_block) begin
                        state_next = raise_fault(state_next, FR_COMPAT_BLOCKED, 1'b0, 1'b0);
                    end else begin
                        state_next.out_valid = 1'b1;
                        state_next.out_addr = state_reg.addr;
                        state_next.out_data = state_reg.data;
                        state_next.out_dest = 32'h0000_0000;
                        state_next.out_remapped = 1'b0;
                        state_next.st = ST_SEND;
                    end
                end else if (dec_rsvd_bad) begin
                    state_next = raise_fault(state_next, FR_RSVD_REQ, 1'b0, 1'b0);
                end else if (dec_bounds_bad) begin
                    state_next = raise_fault(state_next, FR_BOUNDS, 1'b0, 1'b0);
                end else if (cache_hit) begin
                    state_next.entry = cache_entry;
                    state_next.st = ST_VERIFY;
                end else begin
                    state_next.mem_req = 1'b1;
                    state_next.mem_addr = ent_addr;
                    state_next.st = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (mem_ack) begin
                    state_next.mem_req = 1'b0;
                    if (mem_err) begin
                        state_next = raise_fault(state_next, FR_TABLE_ERR, 1'b0, 1'b0);
                    end else begin
                        state_next.entry = mem_rdata;
                        state_next.st = ST_VERIFY;
                    end
                end
            end
            ST_VERIFY: begin
                if (!e_p) begin
                    state_next = raise_fault(state_next, FR_NOT_PRESENT, 1'b1, e_fpd);
                end else if (e_svt_bad) begin
                    state_next = raise_fault(state_next, FR_BAD_ENTRY, 1'b1, e_fpd);
                end else if (!sid_ok) begin
                    state_next = raise_fault(state_next, FR_SID_MISMATCH, 1'b1, e_fpd);
                end else if (e_im) begin
                    state_next.post_valid = 1'b1;
                    state_next.st = ST_POST;
                end else if (e_rsvd_bad) begin
                    state_next = raise_fault(state_next, FR_BAD_ENTRY, 1'b1, e_fpd);
                end else begin
                    state_next.out_valid = 1'b1;
                    state_next.out_addr = {INT_WINDOW, state_reg.entry[E_DEST_LSB +: 8], 8'h00,
                                           state_reg.entry[E_RH_BIT], state_reg.entry[E_DM_BIT], 2'b00};
                    state_next.out_data = {16'h0000, state_reg.entry[E_TM_BIT], 1'b1, 3'b000,
                                           state_reg.entry[E_DLM_LSB +: 3], state_reg.entry[E_VEC_LSB +: 8]};
                    state_next.out_dest = state_reg.entry[E_DEST_LSB +: 32];
                    state_next.out_remapped = 1'b1;
                    state_next.st = ST_SEND;
                end
            end
            ST_SEND: begin
                if (out_ready) begin
                    state_next.out_valid = 1'b0;
                    state_next.fwd_cnt = state_reg.fwd_cnt + 16'h0001;
                    state_next.st = ST_IDLE;
                end
            end
            ST_POST: begin
                if (post_ready) begin
                    state_next.post_valid = 1'b0;
                    state_next.st = ST_IDLE;
                    if (post_desc_err) begin
                        state_next = raise_fault(state_next, FR_DESC_ERR, 1'b1, e_fpd);
                    end else if (post_desc_rsvd) begin
                        state_next = raise_fault(state_next, FR_DESC_RSVD, 1'b1, e_fpd);
                    end
                end
            end
            default: state_next.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
            state_reg.st <= ST_IDLE;
            state_reg.ctrl <= CTRL_RESET;
            state_reg.tsize <= TSIZE_RESET;
            state_reg.base <= BASE_RESET;
            state_reg.host_addr_width <= HAW_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign req_ready = state_reg.st == ST_IDLE;
    assign avs_readdata = state_reg.rdata;
    assign mem_req = state_reg.mem_req;
    assign mem_addr = state_reg.mem_addr;
    assign mem_nosnoop = !coherent;
    assign out_valid = state_reg.out_valid;
    assign out_addr = state_reg.out_addr;
    assign out_data = state_reg.out_data;
    assign out_dest = state_reg.out_dest;
    assign out_remapped = state_reg.out_remapped;
    assign post_valid = state_reg.post_valid;
    assign post_index = state_reg.idx;
    assign post_entry = state_reg.entry;
    assign fault_valid = state_reg.fault_valid;
    assign fault_reason = state_reg.fault_reason;
    assign fault_qualified = state_reg.fault_qualified;
    assign fault_report = state_reg.fault_report;
    assign fault_source_id = state_reg.requester_source_tag;
    assign fault_index = state_reg.idx;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    window_drop_a: assert property ((state_reg.st == ST_IDLE) && req_valid && !in_is_int
        |=> state_reg.st == ST_IDLE) else $error("non-interrupt request was processed");
    disabled_pass_a: assert property ((state_reg.st == ST_DECODE) && !remap_en
        |=> out_valid && !out_remapped && (out_data == $past(state_reg.data))) else $error("pass-through lost");
    compat_block_a: assert property ((state_reg.st == ST_DECODE) && dec_compat_block
        |=> fault_valid && (fault_reason == FR_COMPAT_BLOCKED) && !out_valid) else $error("compat not blocked");
    rsvd_req_a: assert property ((state_reg.st == ST_DECODE) && dec_remappable && dec_rsvd_bad
        |=> fault_valid && (fault_reason == FR_RSVD_REQ)) else $error("reserved request not faulted");
    bounds_fault_a: assert property ((state_reg.st == ST_DECODE) && dec_remappable && !dec_rsvd_bad
        && (state_reg.idx >= state_reg.tsize) |=> fault_valid && (fault_reason == FR_BOUNDS)) else $error("bounds miss");
    nosnoop_fetch_a: assert property (mem_req |-> (mem_nosnoop == !coherent)) else $error("snoop attribute wrong");
    not_present_a: assert property ((state_reg.st == ST_VERIFY) && !e_p
        |=> fault_valid && fault_qualified && (fault_reason == FR_NOT_PRESENT)) else $error("absent entry used");
    fetch_err_a: assert property ((state_reg.st == ST_FETCH) && mem_ack && mem_err
        |=> fault_valid && (fault_reason == FR_TABLE_ERR) && !fault_qualified) else $error("table error lost");
    posted_hand_a: assert property ((state_reg.st == ST_VERIFY) && e_p && !e_svt_bad && sid_ok && e_im
        |=> post_valid && !out_valid) else $error("posted entry not handed over");
    level_asserted_a: assert property (out_valid && out_remapped |-> out_data[14]) else $error("trigger level low");
    report_gate_a: assert property (fault_valid |-> (fault_report == (!fault_qualified || !e_fpd))) else $error("report gate");
    blocked_quiet_a: assert property (fault_valid |-> !out_valid ##1 !out_valid) else $error("blocked request forwarded");

    remap_fwd_c: cover property (out_valid && out_ready && out_remapped);
    compat_fwd_c: cover property (out_valid && out_ready && !out_remapped);
    fault_qual_c: cover property (fault_valid && fault_qualified && !fault_report);
    cache_hit_c: cover property ((state_reg.st == ST_DECODE) && dec_remappable && cache_hit ##1 state_reg.st == ST_VERIFY);
endmodule

// ==== irrc_mem_model.sv ====
// memory side model: answers entry fetches with the entry the bench programs
module irrc_mem_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic mem_req,
    input wire logic [127:0] ent,
    input wire logic fail,
    output logic mem_ack,
    output logic mem_err,
    output logic [127:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] wait_reg;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wait_reg <= 2'h0;
            mem_ack <= 1'b0;
            mem_err <= 1'b0;
            mem_rdata <= '0;
        end else begin
            mem_ack <= 1'b0;
            mem_err <= 1'b0;
            // stale data must not look valid once the answer is gone
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) begin
                wait_reg <= wait_reg + 2'h1;
                if (wait_reg == 2'h2) begin
                    wait_reg <= 2'h0;
                    mem_ack <= 1'b1;
                    mem_err <= fail;
                    mem_rdata <= ent;
                end
            end
        end
    end
endmodule

// ==== tb_top.sv ====
// self-checking bench for the interrupt remap request checker
module tb_top import irrc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic req_valid = 1'b0;
    logic fail = 1'b0;
    logic req_write = 1'b1;
    logic pdesc_err = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [3:0] req_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] req_addr = 32'h0000_0000;
    logic [31:0] req_data = 32'h0000_0000;
    logic [15:0] req_source_id = 16'h0000;
    logic [127:0] ent = '0;
    logic [127:0] mem_rdata;
    logic [31:0] avs_readdata, out_addr, out_data, out_dest, q;
    logic avs_waitrequest, req_ready, mem_req, mem_nosnoop, mem_ack, mem_err, out_valid, out_remapped;
    logic post_valid, fault_valid, fault_qualified, fault_report;
    logic [32:0] mem_addr;
    logic [7:0] fault_reason;
    int err_count = 0;
    int tests_run = 0;
    always #50 sys_clk = ~sys_clk;
    irrc_checker uut (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .req_valid, .req_ready, .req_write, .req_byteenable, .req_addr, .req_data,
        .req_source_id, .mem_req, .mem_addr, .mem_nosnoop, .mem_ack, .mem_err, .mem_rdata, .out_valid,
        .out_ready(1'b1), .out_addr, .out_data, .out_dest, .out_remapped, .post_valid, .post_ready(1'b1),
        .post_desc_err(pdesc_err), .post_desc_rsvd(1'b0), .post_index(), .post_entry(), .fault_valid, .fault_reason,
        .fault_qualified, .fault_report, .fault_source_id(), .fault_index());
    irrc_mem_model mem (.sys_clk, .rst, .mem_req, .ent, .fail, .mem_ack, .mem_err, .mem_rdata);
    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        // waitrequest and readdata are both taken at the same rising edge
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0 && ++n < 20);
        chk({31'h0, avs_waitrequest}, 32'h0000_0000);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // result code: out_data when forwarded, {report, reason} on a fault, dead_0000 if nothing came
    task automatic irq(input logic [31:0] a, input logic [31:0] d, input logic [15:0] s, input logic [3:0] be,
                       input logic [31:0] exp);
        int n;
        n = 0;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_addr <= a;
        req_data <= d;
        req_source_id <= s;
        req_byteenable <= be;
        do @(posedge sys_clk); while (req_ready !== 1'b1 && ++n < 20);
        chk({31'h0, req_ready}, 32'h0000_0001);
        req_valid <= 1'b0;
        q = 32'hdead_0000;
        repeat (20) begin
            @(negedge sys_clk);
            if (out_valid === 1'b1) q = out_data;
            if (fault_valid === 1'b1) q = {23'h0, fault_report, fault_reason};
        end
        chk(q, exp);
        $display("test %0d done", tests_run);
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        bus(1'b0, REG_HAW, 32'h0000_0000);
        chk(q, 32'h0000_0020);
        bus(1'b0, 8'h1c, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        chk({31'h0, mem_nosnoop}, 32'h0000_0001);
        irq(32'hfee0_0000, 32'h0000_0031, 16'h0000, 4'hf, 32'h0000_0031);
        irq(32'hfee0_0010, 32'h0000_0077, 16'h0000, 4'hf, 32'h0000_0077);
        irq(32'hfee0_0000, 32'h0000_0031, 16'h0000, 4'h3, 32'hdead_0000);
        irq(32'hfef0_0000, 32'h0000_0031, 16'h0000, 4'hf, 32'hdead_0000);
        @(posedge sys_clk) req_write <= 1'b0;
        irq(32'hfee0_0000, 32'h0000_0031, 16'h0000, 4'hf, 32'hdead_0000);
        @(posedge sys_clk) req_write <= 1'b1;
        bus(1'b1, REG_CTRL, 32'h0000_0001);
        irq(32'hfee0_0000, 32'h0000_0031, 16'h0000, 4'hf, 32'h0000_0125);
        bus(1'b1, REG_CTRL, 32'h0000_0007);
        irq(32'hfee0_0000, 32'h0000_0031, 16'h0000, 4'hf, 32'h0000_0125);
        bus(1'b1, REG_CTRL, 32'h0000_0003);
        irq(32'hfee0_0000, 32'h0000_0031, 16'h0000, 4'hf, 32'h0000_0031);
        bus(1'b1, REG_TSIZE, 32'h0000_0004);
        irq(32'hfee0_0018, 32'h0001_0000, 16'h0000, 4'hf, 32'h0000_0120);
        irq(32'hfee0_0090, 32'h0000_0000, 16'h0000, 4'hf, 32'h0000_0121);
        irq(32'hfee0_0038, 32'h0000_0003, 16'h0000, 4'hf, 32'h0000_0121);
        ent = 128'h2;
        irq(32'hfee0_0010, 32'h0000_0000, 16'h0000, 4'hf, 32'h0000_0022);
        ent = {44'h0, 2'h3, 18'h0, 64'h1};
        irq(32'hfee0_0018, 32'h0000_0001, 16'h0000, 4'hf, 32'h0000_0124);
        ent = {44'h0, 2'h1, 2'h0, 16'h1234, 64'h1};
        irq(32'hfee0_0050, 32'h0000_0000, 16'h1235, 4'hf, 32'h0000_0126);
        ent = {64'h0, 32'h5, 32'h0041_0011};
        irq(32'hfee0_0070, 32'h0000_0000, 16'h0000, 4'hf, 32'h0000_c041);
        ent = '0;
        irq(32'hfee0_0070, 32'h0000_0000, 16'h0000, 4'hf, 32'h0000_c041);
        bus(1'b1, REG_CTRL, 32'h0000_001b);
        fail = 1'b1;
        irq(32'hfee0_0070, 32'h0000_0000, 16'h0000, 4'hf, 32'h0000_0123);
        chk({31'h0, mem_nosnoop}, 32'h0000_0000);
        fail = 1'b0;
        ent = 128'h8001;
        @(posedge sys_clk) pdesc_err <= 1'b1;
        irq(32'hfee0_0070, 32'h0000_0000, 16'h0000, 4'hf, 32'h0000_0127);
        results;
    end
    initial begin
        #1_000_000;
        err_count++;
        results;
    end
endmodule
